// ### src/pmc_top.sv
// Operation
// RULE1 - standby: oscillator, cpu, peripherals off, ports hiz
// RULE2 - standby wake: restart oscillator, wait, active
// RULE3 - masked or disabled interrupt never wakes
// RULE4 - reset pin restarts oscillator, reset handling after
// RULE5 - watch: oscillator, cpu, most peripherals off
// RULE6 - watch wake: target by speed bits, wait
// RULE7 - subsleep: cpu halted, peripherals except i2c
// RULE8 - subsleep wake returns to subactive with handling
// RULE9 - subactive: oscillator off, watch subclock runs
// RULE10 - subactive sleep: subsleep, active or watch
// RULE11 - subactive clock is watch clock over 1-8
// RULE12 - subactive divider applied only at sleep
// RULE13 - medium speed clock divided by medium_divider
// RULE14 - medium sleep: standby, watch, sleep or direct
// RULE15 - reset pin low abandons medium speed mode
// RULE16 - direct transition passes sleep or watch, handles
// RULE17 - masked direct transition stays in sleep/watch
// RULE18 - high to medium direct via sleep
// RULE19 - high to subactive direct via watch
// RULE20 - direct latency three old plus fourteen new
// RULE21 - sleep wake returns to same speed active
// RULE22 - settling wait counted in system cycles
//
// Decided for this implementation: the register offsets and the APB register port.
`default_nettype none
module pmc_top
   import pmc_pkg::*;
#(
   parameter int WAIT_UNIT = 16
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sleep_exec,
   input wire logic irq_req,
   input wire logic interrupt_mask,
   input wire logic reset_pin_n,
   input wire logic watch_clk,
   output logic osc_run,
   output logic cpu_run,
   output logic cpu_clk_en,
   output logic periph_run,
   output logic periph_clk_en,
   output logic watch_periph_run,
   output logic i2c_run,
   output logic io_hiz,
   output logic cpu_reset,
   output logic reset_exc,
   output logic exc_start,
   output logic direct_exc
);
   // ==================================================================
   // decoding helpers
   function automatic logic reg_hit(input logic [11:0] a,
                                    input logic [11:0] off);
      reg_hit = (a[11:2] == off[11:2]);
   endfunction

   function automatic logic [3:0] div_limit(input logic [1:0] sel,
                                            input logic [2:0] base);
      div_limit = 4'((5'h01 << (3'(sel) + base)) - 5'h01);
   endfunction

   function automatic pmc_clk_t clk_of(input pmc_state_t s);
      case (s)
         ST_ACT_MED: clk_of = CK_MED;
         ST_SUBACT: clk_of = CK_SUB;
         default: clk_of = CK_HI;
      endcase
   endfunction

   // ==================================================================
   // pin synchronisers
   logic rp_meta_q, rp_sync_q;
   logic wc_meta_q, wc_sync_q, wc_prev_q;
   logic watch_edge;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rp_meta_q <= 1'b0;
         rp_sync_q <= 1'b0;
         wc_meta_q <= 1'b0;
         wc_sync_q <= 1'b0;
         wc_prev_q <= 1'b0;
      end
      else
      begin
         rp_meta_q <= reset_pin_n;
         rp_sync_q <= rp_meta_q;
         wc_meta_q <= watch_clk;
         wc_sync_q <= wc_meta_q;
         wc_prev_q <= wc_sync_q;
      end
   end

   assign watch_edge = wc_sync_q & ~wc_prev_q;

   // ==================================================================
   // control registers over apb
   logic [7:0] ctrl1_q;
   logic [3:0] ctrl2_q;
   logic [1:0] sub_div_q;
   logic [31:0] prdata_q;
   logic pready_q, pslverr_q;
   logic wr_en, rd_take, mapped;
   logic [31:0] rd_mux;
   logic sw_stby, watch_sel, low_spd, med_spd, direct;
   logic [2:0] wait_sel;
   logic [1:0] med_div;
   pmc_state_t state_q, state_d, tgt_q, tgt_d;
   pmc_clk_t clk_q, clk_d;

   assign sw_stby = ctrl1_q[BIT_SW_STANDBY];
   assign watch_sel = ctrl1_q[BIT_WATCH_SELECT];
   assign wait_sel = ctrl1_q[POS_WAIT_SELECT +: 3];
   assign low_spd = ctrl1_q[BIT_LOW_SPEED];
   assign med_div = ctrl1_q[POS_MED_DIVIDER +: 2];
   assign med_spd = ctrl2_q[BIT_MED_SPEED];
   assign direct = ctrl2_q[BIT_DIRECT];

   assign wr_en = psel & penable & pwrite & pready_q;
   assign rd_take = psel & penable & ~pready_q;
   assign mapped = reg_hit(paddr, OFF_SYS_CTRL_ONE) |
                   reg_hit(paddr, OFF_SYS_CTRL_TWO) |
                   reg_hit(paddr, OFF_STATUS);

   always_comb
   begin
      rd_mux = 32'h0;
      if (reg_hit(paddr, OFF_SYS_CTRL_ONE))
         rd_mux[7:0] = ctrl1_q;
      else if (reg_hit(paddr, OFF_SYS_CTRL_TWO))
         rd_mux[3:0] = ctrl2_q;
      else if (reg_hit(paddr, OFF_STATUS))
      begin
         rd_mux[POS_STATE +: 12] = state_q;
         rd_mux[POS_CLK_MODE +: 2] = clk_q;
      end
   end

   // one wait state: pready rises on the second access cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end
      else if (rd_take)
      begin
         pready_q <= 1'b1;
         pslverr_q <= ~mapped;
         prdata_q <= pwrite ? 32'h0 : rd_mux;
      end
      else
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end
   end

   // pin reset clears the mode bits like a power-on
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl1_q <= RST_SYS_CTRL_ONE;
         ctrl2_q <= RST_SYS_CTRL_TWO;
      end
      else if (!rp_sync_q)
      begin
         ctrl1_q <= RST_SYS_CTRL_ONE;
         ctrl2_q <= RST_SYS_CTRL_TWO;
      end
      else if (wr_en && reg_hit(paddr, OFF_SYS_CTRL_ONE))
         ctrl1_q <= pwdata[7:0];
      else if (wr_en && reg_hit(paddr, OFF_SYS_CTRL_TWO))
         ctrl2_q <= pwdata[3:0];
   end

   // running divider held until sleep so the cpu never sees a glitch
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sub_div_q <= 2'h0;
      else if (sleep_exec)
         sub_div_q <= ctrl2_q[POS_SUB_DIVIDER +: 2]; // [RULE12]
   end

   // ==================================================================
   // clock dividers
   pmc_div_if med_if ();
   pmc_div_if sub_if ();
   logic cur_tick;

   assign med_if.src_tick = 1'b1;
   assign med_if.limit = div_limit(med_div, 3'h1); // [RULE13]
   assign sub_if.src_tick = watch_edge;
   assign sub_if.limit = div_limit(sub_div_q, 3'h0); // [RULE11]

   pmc_div u_med_div (.pclk(pclk), .presetn(presetn), .dv(med_if));
   pmc_div u_sub_div (.pclk(pclk), .presetn(presetn), .dv(sub_if));

   always_comb
   begin
      case (clk_q)
         CK_MED: cur_tick = med_if.tick;
         CK_SUB: cur_tick = sub_if.tick; // [RULE9]
         default: cur_tick = 1'b1;
      endcase
   end

   // ==================================================================
   // mode state machine
   logic [CNT_W-1:0] cnt_q, cnt_d, wait_cnt;
   logic dir_q, dir_d, wake;
   pmc_state_t spd_tgt;

   assign wake = irq_req & ~interrupt_mask; // [RULE3]
   assign wait_cnt = CNT_W'((WAIT_UNIT << wait_sel) - 1); // [RULE22]
   assign spd_tgt = med_spd ? ST_ACT_MED : ST_ACT_HI;

   always_comb
   begin
      state_d = state_q;
      tgt_d = tgt_q;
      clk_d = clk_q;
      cnt_d = cnt_q;
      dir_d = dir_q;
      if (!rp_sync_q)
      begin
         state_d = ST_RST; // [RULE4] [RULE15]
         clk_d = CK_HI;
         dir_d = 1'b0;
      end
      else
         case (state_q)
            ST_RST: state_d = ST_ACT_HI;
            ST_ACT_HI, ST_ACT_MED:
               if (sleep_exec && !sw_stby) // [RULE14]
               begin
                  if (direct && !interrupt_mask) // [RULE18] [RULE16]
                  begin
                     state_d = ST_VIA;
                     tgt_d = spd_tgt;
                     cnt_d = '0;
                     dir_d = 1'b1;
                  end
                  else if (state_q == ST_ACT_MED) // [RULE17]
                     state_d = ST_SLEEP_MED;
                  else
                     state_d = ST_SLEEP_HI;
               end
               else if (sleep_exec && !watch_sel)
                  state_d = ST_STANDBY;
               else if (sleep_exec)
               begin
                  if (direct && low_spd && !interrupt_mask) // [RULE19]
                  begin
                     state_d = ST_VIA;
                     tgt_d = ST_SUBACT;
                     cnt_d = '0;
                     dir_d = 1'b1;
                  end
                  else
                     state_d = ST_WATCH; // [RULE17]
               end
            ST_SUBACT:
               if (sleep_exec && !sw_stby) // [RULE10]
                  state_d = ST_SUBSLEEP;
               else if (sleep_exec && watch_sel && direct && !low_spd &&
                        !interrupt_mask) // [RULE16]
               begin
                  state_d = ST_VIA;
                  tgt_d = spd_tgt;
                  cnt_d = '0;
                  dir_d = 1'b1;
               end
               else if (sleep_exec)
                  state_d = ST_WATCH; // [RULE17]
            ST_SLEEP_HI, ST_SLEEP_MED:
               if (wake) // [RULE21]
               begin
                  state_d = ST_EXC;
                  tgt_d = (state_q == ST_SLEEP_MED) ? ST_ACT_MED : ST_ACT_HI;
                  cnt_d = '0;
               end
            ST_STANDBY:
               if (wake) // [RULE2]
               begin
                  state_d = ST_OSC_WAIT;
                  tgt_d = spd_tgt;
                  cnt_d = wait_cnt;
               end
            ST_WATCH:
               if (wake && low_spd) // [RULE6]
               begin
                  state_d = ST_EXC;
                  tgt_d = ST_SUBACT;
                  clk_d = CK_SUB;
                  cnt_d = '0;
               end
               else if (wake)
               begin
                  state_d = ST_OSC_WAIT;
                  tgt_d = spd_tgt;
                  cnt_d = wait_cnt;
               end
            ST_SUBSLEEP:
               if (wake) // [RULE8]
               begin
                  state_d = ST_EXC;
                  tgt_d = ST_SUBACT;
                  cnt_d = '0;
               end
            ST_VIA:
               if (cur_tick && cnt_q == VIA_LAST) // [RULE20]
               begin
                  if (clk_q == CK_SUB && tgt_q != ST_SUBACT)
                  begin
                     state_d = ST_OSC_WAIT;
                     cnt_d = wait_cnt;
                  end
                  else
                  begin
                     state_d = ST_EXC;
                     clk_d = clk_of(tgt_q);
                     cnt_d = '0;
                  end
               end
               else if (cur_tick)
                  cnt_d = cnt_q + 1'b1;
            ST_OSC_WAIT:
               if (cnt_q == '0) // [RULE22]
               begin
                  state_d = ST_EXC;
                  clk_d = clk_of(tgt_q);
               end
               else
                  cnt_d = cnt_q - 1'b1;
            ST_EXC:
               if (cur_tick && cnt_q == EXC_LAST) // [RULE20]
               begin
                  state_d = tgt_q;
                  dir_d = 1'b0;
               end
               else if (cur_tick)
                  cnt_d = cnt_q + 1'b1;
            default: state_d = ST_RST;
         endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= ST_RST;
         tgt_q <= ST_ACT_HI;
         clk_q <= CK_HI;
         cnt_q <= '0;
         dir_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         tgt_q <= tgt_d;
         clk_q <= clk_d;
         cnt_q <= cnt_d;
         dir_q <= dir_d;
      end
   end

   // ==================================================================
   // clock and power gating outputs
   logic osc_d, cpu_d, per_d, wper_d, via_watch;

   // watchdog, event counter and comparators are never gated here
   always_comb
   begin
      via_watch = (tgt_d == ST_SUBACT) || (clk_d == CK_SUB);
      osc_d = !(state_d inside {ST_STANDBY, ST_WATCH, ST_SUBSLEEP,
                ST_SUBACT}) && !(state_d == ST_EXC && clk_d == CK_SUB) &&
              !(state_d inside {ST_VIA, ST_OSC_WAIT} && via_watch &&
                state_d != ST_OSC_WAIT); // [RULE1] [RULE5] [RULE9] [RULE4]
      cpu_d = state_d inside {ST_ACT_HI, ST_ACT_MED, ST_SUBACT, ST_EXC};
      per_d = !(state_d inside {ST_STANDBY, ST_WATCH}); // [RULE7]
      wper_d = (state_d != ST_STANDBY); // [RULE5]
   end

   logic osc_q, cpu_q, cpu_ck_q, per_q, per_ck_q, wper_q, i2c_q, hiz_q;
   logic crst_q, rexc_q, exc_q, dexc_q;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         osc_q <= 1'b1;
         cpu_q <= 1'b0;
         cpu_ck_q <= 1'b0;
         per_q <= 1'b1;
         per_ck_q <= 1'b0;
         wper_q <= 1'b1;
         i2c_q <= 1'b1;
         hiz_q <= 1'b0;
         crst_q <= 1'b1;
         rexc_q <= 1'b0;
         exc_q <= 1'b0;
         dexc_q <= 1'b0;
      end
      else
      begin
         osc_q <= osc_d;
         cpu_q <= cpu_d;
         cpu_ck_q <= cpu_d & cur_tick;
         per_q <= per_d;
         per_ck_q <= per_d & cur_tick;
         wper_q <= wper_d;
         i2c_q <= per_d & (clk_d != CK_SUB); // [RULE7] [RULE9]
         hiz_q <= (state_d == ST_STANDBY); // [RULE1]
         crst_q <= (state_d == ST_RST);
         rexc_q <= (state_q == ST_RST) && (state_d == ST_ACT_HI);
         exc_q <= (state_d == ST_EXC) && (state_q != ST_EXC);
         dexc_q <= (state_d == ST_EXC) && dir_d; // [RULE16]
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign osc_run = osc_q;
   assign cpu_run = cpu_q;
   assign cpu_clk_en = cpu_ck_q;
   assign periph_run = per_q;
   assign periph_clk_en = per_ck_q;
   assign watch_periph_run = wper_q;
   assign i2c_run = i2c_q;
   assign io_hiz = hiz_q;
   assign cpu_reset = crst_q;
   assign reset_exc = rexc_q;
   assign exc_start = exc_q;
   assign direct_exc = dexc_q;

   // ==================================================================
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_direct_med;
      state_q == ST_ACT_HI && sleep_exec && !sw_stby && direct &&
      med_spd && !interrupt_mask && rp_sync_q;
   endsequence
   sequence s_via_hi_entry;
      state_q == ST_VIA && clk_q == CK_HI && cnt_q == '0 &&
      $past(state_q) != ST_VIA;
   endsequence

   property p_standby_off;
      state_q == ST_STANDBY |-> !osc_run && io_hiz && !cpu_run;
   endproperty
   a_standby_off: assert property (p_standby_off) // [RULE1]
      else $error("standby gating wrong");
   property p_standby_wake;
      state_q == ST_STANDBY && wake && rp_sync_q |=>
         state_q == ST_OSC_WAIT && osc_run && cnt_q == wait_cnt;
   endproperty
   a_standby_wake: assert property (p_standby_wake) // [RULE2]
      else $error("standby wake did not start settling");
   property p_masked_stay;
      state_q inside {ST_STANDBY, ST_WATCH, ST_SUBSLEEP, ST_SLEEP_HI,
         ST_SLEEP_MED} && interrupt_mask && rp_sync_q |=> $stable(state_q);
   endproperty
   a_masked_stay: assert property (p_masked_stay) // [RULE3]
      else $error("masked interrupt left low power mode");
   property p_pin_reset;
      !rp_sync_q |=> state_q == ST_RST && cpu_reset && osc_run;
   endproperty
   a_pin_reset: assert property (p_pin_reset) // [RULE4]
      else $error("pin reset not honoured");
   property p_watch_gate;
      state_q == ST_WATCH |-> !osc_run && !periph_run &&
         watch_periph_run && !io_hiz;
   endproperty
   a_watch_gate: assert property (p_watch_gate) // [RULE5]
      else $error("watch gating wrong");
   property p_subsleep_wake;
      state_q == ST_SUBSLEEP && wake && rp_sync_q |=>
         state_q == ST_EXC && tgt_q == ST_SUBACT && exc_start;
   endproperty
   a_subsleep_wake: assert property (p_subsleep_wake) // [RULE8]
      else $error("subsleep wake wrong");
   property p_sub_div_hold;
      !sleep_exec |=> $stable(sub_div_q);
   endproperty
   a_sub_div_hold: assert property (p_sub_div_hold) // [RULE12]
      else $error("subactive divider changed without sleep");
   property p_direct_med;
      s_direct_med |=> state_q == ST_VIA && tgt_q == ST_ACT_MED;
   endproperty
   a_direct_med: assert property (p_direct_med) // [RULE18]
      else $error("direct high to medium not taken");
   property p_via_len;
      s_via_hi_entry ##0 rp_sync_q [*3] |=> state_q == ST_EXC;
   endproperty
   a_via_len: assert property (p_via_len) // [RULE20]
      else $error("via phase length wrong");
   property p_masked_direct;
      state_q == ST_ACT_HI && sleep_exec && !sw_stby && direct &&
         interrupt_mask && rp_sync_q |=> state_q == ST_SLEEP_HI;
   endproperty
   a_masked_direct: assert property (p_masked_direct) // [RULE17]
      else $error("masked direct transition not parked");
endmodule // pmc_top
`default_nettype wire

// ### src/pmc_pkg.sv
`default_nettype none
package pmc_pkg;
   // ==================================================================
   // register map
   localparam logic [11:0] OFF_SYS_CTRL_ONE = 12'h000;
   localparam logic [11:0] OFF_SYS_CTRL_TWO = 12'h004;
   localparam logic [11:0] OFF_STATUS = 12'h008;
   // ==================================================================
   // sys_ctrl_one fields
   localparam int BIT_SW_STANDBY = 0;
   localparam int BIT_WATCH_SELECT = 1;
   localparam int POS_WAIT_SELECT = 2;
   localparam int BIT_LOW_SPEED = 5;
   localparam int POS_MED_DIVIDER = 6;
   localparam logic [7:0] RST_SYS_CTRL_ONE = 8'h00;
   // ==================================================================
   // sys_ctrl_two fields
   localparam int BIT_MED_SPEED = 0;
   localparam int BIT_DIRECT = 1;
   localparam int POS_SUB_DIVIDER = 2;
   localparam logic [3:0] RST_SYS_CTRL_TWO = 4'h0;
   // ==================================================================
   // status fields
   localparam int POS_STATE = 0;
   localparam int POS_CLK_MODE = 12;
   // ==================================================================
   // timing in cpu states
   localparam int SLEEP_EXEC_STATES = 2;
   localparam int INTERNAL_STATES = 1;
   localparam int VIA_STATES = SLEEP_EXEC_STATES + INTERNAL_STATES;
   localparam int EXC_STATES = 14;
   localparam int CNT_W = 16;
   localparam logic [15:0] VIA_LAST = 16'(VIA_STATES - 1);
   localparam logic [15:0] EXC_LAST = 16'(EXC_STATES - 1);
   // ==================================================================
   // types
   typedef enum logic [11:0] {
      ST_ACT_HI = 12'h001,
      ST_ACT_MED = 12'h002,
      ST_SLEEP_HI = 12'h004,
      ST_SLEEP_MED = 12'h008,
      ST_STANDBY = 12'h010,
      ST_WATCH = 12'h020,
      ST_SUBSLEEP = 12'h040,
      ST_SUBACT = 12'h080,
      ST_VIA = 12'h100,
      ST_OSC_WAIT = 12'h200,
      ST_EXC = 12'h400,
      ST_RST = 12'h800
   } pmc_state_t;
   typedef enum logic [1:0] {
      CK_HI = 2'h0,
      CK_MED = 2'h1,
      CK_SUB = 2'h2
   } pmc_clk_t;
endpackage
`default_nettype wire

// ### src/pmc_div_if.sv
`default_nettype none
interface pmc_div_if;
   logic src_tick;
   logic [3:0] limit;
   logic tick;
   modport ctrl (output src_tick, output limit, input tick);
   modport div (input src_tick, input limit, output tick);
endinterface
`default_nettype wire

// ### src/pmc_div.sv
`default_nettype none
module pmc_div
(
   input wire logic pclk,
   input wire logic presetn,
   pmc_div_if.div dv
);
   logic [3:0] cnt_q;
   logic tick_q;

   // ==================================================================
   // divide source ticks by limit+1
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_q <= 4'h0;
         tick_q <= 1'b0;
      end
      else if (dv.src_tick)
      begin
         if (cnt_q >= dv.limit)
         begin
            cnt_q <= 4'h0;
            tick_q <= 1'b1;
         end
         else
         begin
            cnt_q <= cnt_q + 4'h1;
            tick_q <= 1'b0;
         end
      end
      else
         tick_q <= 1'b0;
   end

   assign dv.tick = tick_q;
endmodule // pmc_div
`default_nettype wire

// ### testbench/pmc_cpu_model.sv
`default_nettype none
module pmc_cpu_model
#(
   parameter int REL_CYCLES = 24
)
(
   input wire logic pclk,
   input wire logic exc_start,
   output logic sleep_exec,
   output logic irq_req,
   output logic interrupt_mask,
   output logic reset_pin_n,
   output logic watch_clk
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] wcnt_q = 3'h0;
   // ==========
   // watch crystal
   // free running, eight system cycles a period, well below pclk/2
   always @(posedge pclk) wcnt_q <= wcnt_q + 3'h1;
   assign watch_clk = wcnt_q[2];
   // ==========
   // cpu side
   initial
   begin
      sleep_exec = 1'b0;
      irq_req = 1'b0;
      interrupt_mask = 1'b0;
      reset_pin_n = 1'b1;
   end
   // request withdrawn once handling starts, as real logic does
   always @(posedge pclk) if (exc_start === 1'b1) irq_req <= 1'b0;
   task automatic sleep_op();
      @(posedge pclk);
      sleep_exec <= 1'b1;
      @(posedge pclk);
      sleep_exec <= 1'b0;
   endtask
   task automatic raise_irq(input logic m);
      @(posedge pclk);
      interrupt_mask <= m;
      irq_req <= 1'b1;
   endtask
   // held low past settling and release time
   task automatic pin_reset();
      @(posedge pclk);
      reset_pin_n <= 1'b0;
      repeat (REL_CYCLES) @(posedge pclk);
      reset_pin_n <= 1'b1;
   endtask
endmodule // pmc_cpu_model
`default_nettype wire

// ### testbench/power_mode_controller_tb.sv
`default_nettype none
`define CHK(a, b) \
   begin \
      total_checks++; \
      if ((a) !== (b)) \
      begin \
         n_fail++; \
         $display("mismatch t=%0t got %h exp %h", $time, a, b); \
      end \
   end
module power_mode_controller_tb
   import pmc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int WU = 1;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata, rdat;
   logic pready, pslverr, rerr;
   logic sleep_exec, irq_req, interrupt_mask, reset_pin_n, watch_clk;
   logic osc_run, cpu_run, cpu_clk_en, periph_run, periph_clk_en;
   logic watch_periph_run, i2c_run, io_hiz, cpu_reset, reset_exc;
   logic exc_start, direct_exc;
   int n_fail = 0, total_checks = 0, n_rexc = 0, n;
   // ==========
   // harness
   always #12.5 pclk = ~pclk;
   always @(negedge pclk) if (reset_exc === 1'b1) n_rexc++;
   pmc_top #(.WAIT_UNIT(WU)) pmc_top_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sleep_exec(sleep_exec), .irq_req(irq_req),
      .interrupt_mask(interrupt_mask), .reset_pin_n(reset_pin_n),
      .watch_clk(watch_clk), .osc_run(osc_run), .cpu_run(cpu_run),
      .cpu_clk_en(cpu_clk_en), .periph_run(periph_run),
      .periph_clk_en(periph_clk_en), .watch_periph_run(watch_periph_run),
      .i2c_run(i2c_run), .io_hiz(io_hiz), .cpu_reset(cpu_reset),
      .reset_exc(reset_exc), .exc_start(exc_start),
      .direct_exc(direct_exc));
   pmc_cpu_model cpu_i (.pclk(pclk), .exc_start(exc_start),
      .sleep_exec(sleep_exec), .irq_req(irq_req),
      .interrupt_mask(interrupt_mask), .reset_pin_n(reset_pin_n),
      .watch_clk(watch_clk));
   // ==========
   // tasks
   task automatic stop_test();
      if (n_fail == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int i;
      i = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1 && ++i < 50);
      if (pready !== 1'b1) n_fail++;
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_st(input pmc_state_t s);
      int i;
      i = 0;
      do apb(1'b0, OFF_STATUS, 32'h0);
      while (rdat[11:0] !== s && ++i < 400);
      @(negedge pclk);
      `CHK(rdat[11:0], s)
   endtask
   task automatic wait_exc(output int c);
      c = 0;
      do @(negedge pclk); while (exc_start !== 1'b1 && ++c < 3000);
      if (exc_start !== 1'b1) n_fail++;
      c++;
   endtask
   // cycles between two cpu clock enables
   task automatic gap(input int expv);
      int c;
      c = 0;
      do @(negedge pclk); while (cpu_clk_en !== 1'b1 && ++c < 900);
      c = 0;
      do @(negedge pclk); while (cpu_clk_en !== 1'b1 && ++c < 900);
      `CHK(c + 1, expv)
      `CHK(periph_clk_en, 1'b1)
   endtask
   // ==========
   // sequence
   initial
   begin
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= 12'h000;
      pwdata <= 32'h0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      wait_st(ST_ACT_HI);
      `CHK(n_rexc, 1)
      apb(1'b0, OFF_SYS_CTRL_TWO, 32'h0);
      `CHK(rdat, 32'(RST_SYS_CTRL_TWO))
      apb(1'b0, 12'h00c, 32'h0);
      `CHK({rerr, rdat}, 33'h100000000)
      apb(1'b1, OFF_SYS_CTRL_TWO, 32'h3);
      cpu_i.sleep_op();
      wait_exc(n);
      `CHK(n, VIA_STATES + 1)
      n = 0;
      while (direct_exc === 1'b1 && n < 100)
      begin
         @(negedge pclk);
         n++;
      end
      `CHK(n, EXC_STATES * 2)
      wait_st(ST_ACT_MED);
      `CHK(rdat[13:12], CK_MED)
      apb(1'b1, OFF_SYS_CTRL_ONE, 32'h40);
      gap(4);
      apb(1'b1, OFF_SYS_CTRL_TWO, 32'h1);
      cpu_i.sleep_op();
      wait_st(ST_SLEEP_MED);
      cpu_i.raise_irq(1'b1);
      repeat (30) @(negedge pclk);
      wait_st(ST_SLEEP_MED);
      cpu_i.raise_irq(1'b0);
      wait_st(ST_ACT_MED);
      fork
         cpu_i.pin_reset();
      join_none
      wait_st(ST_RST);
      `CHK(cpu_reset, 1'b1)
      wait_st(ST_ACT_HI);
      `CHK(n_rexc, 2)
      apb(1'b1, OFF_SYS_CTRL_ONE, 32'h0d);
      cpu_i.sleep_op();
      wait_st(ST_STANDBY);
      `CHK({io_hiz, osc_run, cpu_run}, 3'h4)
      cpu_i.raise_irq(1'b0);
      wait_exc(n);
      `CHK(n > (WU << 3), 1'b1)
      `CHK(osc_run, 1'b1)
      wait_st(ST_ACT_HI);
      apb(1'b1, OFF_SYS_CTRL_TWO, 32'h6);
      apb(1'b1, OFF_SYS_CTRL_ONE, 32'h23);
      cpu_i.sleep_op();
      wait_st(ST_SUBACT);
      `CHK({osc_run, cpu_run, i2c_run}, 3'h2)
      gap(16);
      apb(1'b1, OFF_SYS_CTRL_TWO, 32'hc);
      gap(16);
      apb(1'b1, OFF_SYS_CTRL_ONE, 32'h20);
      cpu_i.sleep_op();
      wait_st(ST_SUBSLEEP);
      `CHK({cpu_run, periph_run, i2c_run}, 3'h2)
      cpu_i.raise_irq(1'b0);
      wait_st(ST_SUBACT);
      gap(64);
      apb(1'b1, OFF_SYS_CTRL_TWO, 32'h0);
      apb(1'b1, OFF_SYS_CTRL_ONE, 32'h03);
      cpu_i.sleep_op();
      wait_st(ST_WATCH);
      `CHK({osc_run, cpu_run, watch_periph_run, io_hiz}, 4'h2)
      cpu_i.raise_irq(1'b0);
      wait_st(ST_ACT_HI);
      apb(1'b1, OFF_SYS_CTRL_TWO, 32'h3);
      apb(1'b1, OFF_SYS_CTRL_ONE, 32'h0);
      cpu_i.raise_irq(1'b1);
      cpu_i.sleep_op();
      repeat (60) @(negedge pclk);
      wait_st(ST_SLEEP_HI);
      stop_test();
   end
   // hang guard, far above the expected few thousand cycles
   initial
   begin
      repeat (30000) @(posedge pclk);
      n_fail++;
      stop_test();
   end
endmodule // power_mode_controller_tb
`default_nettype wire
